// file: common/ais_map.svh
// register offsets, field positions, reset values and counts of the alarm block
`ifndef AIS_MAP_SVH
`define AIS_MAP_SVH

// ***************************************************
// register offsets
// ***************************************************
`define AIS_ADDR_ENABLE 16'h00C7
`define AIS_ADDR_EN_RSVD 16'h00C8
`define AIS_ADDR_STATUS 16'h0200
`define AIS_ADDR_ST_RSVD_A 16'h0201
`define AIS_ADDR_ST_RSVD_B 16'h0202
`define AIS_ADDR_ST_RSVD_C 16'h0203
`define AIS_ADDR_BUSY 16'h0204

// ***************************************************
// field positions
// ***************************************************
`define AIS_LOCK_LOSS_LSB 6
`define AIS_HOLDOVER_LSB 4
`define AIS_SIGNAL_LOSS_LSB 0

// ***************************************************
// reset values and counts
// ***************************************************
`define AIS_ENABLE_RST 8'h00
`define AIS_STATUS_RST 8'h00
`define AIS_RSVD_READ 8'h00
`define AIS_LOS_COUNT_DFLT 17'h1FFFF
`define AIS_LOS_COUNT_MIN 17'h00003

`endif

// file: common/ais_pkg.sv
// types shared by the alarm status block
package ais_pkg;
   typedef logic [7:0] ais_byte_t;
   typedef logic [16:0] ais_count_t;
   // signal-loss watchdog states, one-hot
   typedef enum logic [1:0] {
      AIS_WATCH = 2'b01,
      AIS_LOST = 2'b10
   } ais_wd_state_e;
endpackage

// file: common/ais_wd_if.sv
// link between the alarm block and one signal-loss watchdog
`timescale 1ns/1ps
interface ais_wd_if;
   logic tick;
   logic ref_edge;
   logic [16:0] period;
   logic alarm;
   modport mon (input tick, input ref_edge, input period, output alarm);
   modport ctl (output tick, output ref_edge, output period, input alarm);
endinterface

// file: hw/ais_los_wd.sv
// signal-loss watchdog for one input reference
`timescale 1ns/1ps
`include "ais_map.svh"
module ais_los_wd
   import ais_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // watchdog link
   ais_wd_if.mon wd
);
   ais_wd_state_e state_reg, state_next;
   ais_count_t count_reg, count_next;
   ais_count_t limit;

   // settings below the minimum would alarm on healthy references
   function automatic ais_count_t clamp_limit(input ais_count_t p);
      clamp_limit = (p < `AIS_LOS_COUNT_MIN) ? `AIS_LOS_COUNT_MIN : p;
   endfunction

   // ***************************************************
   // watchdog state
   // ***************************************************
   always_comb begin
      limit = clamp_limit(wd.period);
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         AIS_WATCH: begin
            if (wd.ref_edge) begin
               count_next = 17'h00000;
            end else if (wd.tick) begin
               if (count_reg + 17'h00001 >= limit) begin
                  state_next = AIS_LOST;
                  count_next = 17'h00000;
               end else begin
                  count_next = count_reg + 17'h00001;
               end
            end
         end
         AIS_LOST: begin
            count_next = 17'h00000;
            if (wd.ref_edge) begin
               state_next = AIS_WATCH;
            end
         end
         default: begin
            state_next = AIS_WATCH;
            count_next = 17'h00000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= AIS_WATCH;
         count_reg <= 17'h00000;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   assign wd.alarm = (state_reg == AIS_LOST);

   // ***************************************************
   // checks
   // ***************************************************
   chk_los_raise: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == AIS_WATCH && !wd.ref_edge && wd.tick
       && count_reg + 17'h00001 >= clamp_limit(wd.period))
      |=> wd.alarm)
      else $error("signal loss not raised at the programmed count");

   chk_los_count: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == AIS_WATCH) |-> (count_reg < clamp_limit(wd.period)))
      else $error("watchdog count passed its limit");
endmodule

// file: hw/ais_top.sv
// alarm interrupt status block: sticky flags, enables and interrupt pin
`timescale 1ns/1ps
`include "ais_map.svh"

// Overview of operation
// - lock-loss enables reset to 0; when 0 that flag cannot pull the pin
// - holdover enables reset to 0; when 1 that flag may pull the pin
// - signal-loss enables reset to 0; 1 lets the flag drive, 0 masks it
// - enable register ALARM_IRQ_ENABLE: lock-loss 7:6, holdover 5:4, signal-loss 3:0
// - every alarm event sets its status flag whatever its enable says
// - status flags are sticky and stay set after the alarm goes away
// - writing 1 clears a flag, writing 0 leaves it, reads show it
// - status register 0200 uses the same layout; all flags reset to 0
// - lock-loss flag is 1 if any lock-loss alarm since last clear
// - holdover flag is 1 if any holdover alarm since last clear
// - signal-loss flag is 1 if any signal-loss alarm since last clear
// - read-only register 0204 gives one busy flag per output, 7 to 0
// - busy flag reads 1 while that output has a phase adjustment running
// - signal loss raised after programmed tick count without edge, min 3
module ais_top
   import ais_pkg::*;
#(
   parameter int NUM_REFS = 4,
   parameter int NUM_PLLS = 2,
   parameter int NUM_OUTS = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port from the serial port engine
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // alarm sources on this clock
   input wire logic [NUM_PLLS-1:0] lock_loss_alarm_i,
   input wire logic [NUM_PLLS-1:0] holdover_alarm_i,
   // input references and their monitors
   input wire logic [NUM_REFS-1:0] ref_clk_i,
   input wire logic monitor_tick_i,
   input wire logic [NUM_REFS*17-1:0] signal_loss_period_count_i,
   // phase adjustment engine
   input wire logic [NUM_OUTS-1:0] phase_adjust_in_progress_i,
   // interrupt pin
   output logic interrupt_out_n_o
);
   // ***************************************************
   // declarations
   // ***************************************************
   ais_byte_t enable_reg, enable_next;
   ais_byte_t status_reg, status_next;
   ais_byte_t busy_reg, busy_next;
   ais_byte_t rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic irq_n_reg, irq_n_next;
   logic [NUM_REFS-1:0] ref_s1_reg, ref_s2_reg, ref_s3_reg;
   logic [NUM_REFS-1:0] ref_level_reg, ref_level_next;
   logic [NUM_REFS-1:0] ref_edge;
   logic [NUM_REFS-1:0] los_alarm;
   ais_byte_t events;
   ais_byte_t clr_mask;
   logic wr_enable, wr_status;

   // ***************************************************
   // reference pin synchronisers
   // ***************************************************
   // a change counts only when stages two and three agree
   always_comb begin
      ref_level_next = ref_level_reg;
      for (int i = 0; i < NUM_REFS; i++) begin
         if (ref_s2_reg[i] == ref_s3_reg[i]) begin
            ref_level_next[i] = ref_s3_reg[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_s1_reg <= '0;
         ref_s2_reg <= '0;
         ref_s3_reg <= '0;
         ref_level_reg <= '0;
      end else begin
         ref_s1_reg <= ref_clk_i;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         ref_level_reg <= ref_level_next;
      end
   end

   // rising edges only; one per reference period
   assign ref_edge = ref_level_next & ~ref_level_reg;

   // ***************************************************
   // signal-loss watchdogs
   // ***************************************************
   ais_wd_if wd_bus [NUM_REFS] ();

   for (genvar g = 0; g < NUM_REFS; g++) begin : g_wd
      assign wd_bus[g].tick = monitor_tick_i;
      assign wd_bus[g].ref_edge = ref_edge[g];
      assign wd_bus[g].period = signal_loss_period_count_i[g*17 +: 17];
      assign los_alarm[g] = wd_bus[g].alarm;
      ais_los_wd u_wd (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .wd(wd_bus[g].mon)
      );
   end

   // ***************************************************
   // register access decode
   // ***************************************************
   assign wr_enable = reg_wr_i && (reg_addr_i == `AIS_ADDR_ENABLE);
   assign wr_status = reg_wr_i && (reg_addr_i == `AIS_ADDR_STATUS);
   assign clr_mask = wr_status ? reg_wdata_i : 8'h00;

   // event vector in register layout
   always_comb begin
      events = 8'h00;
      events[`AIS_LOCK_LOSS_LSB +: 2] = lock_loss_alarm_i[1:0];
      events[`AIS_HOLDOVER_LSB +: 2] = holdover_alarm_i[1:0];
      events[`AIS_SIGNAL_LOSS_LSB +: 4] = los_alarm[3:0];
   end

   // ***************************************************
   // enable, sticky status and busy
   // ***************************************************
   always_comb begin
      enable_next = enable_reg;
      if (wr_enable) begin
         enable_next = reg_wdata_i;
      end
      // set wins over a clear in the same cycle
      status_next = (status_reg & ~clr_mask) | events;
      busy_next = phase_adjust_in_progress_i[7:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg <= `AIS_ENABLE_RST;
         status_reg <= `AIS_STATUS_RST;
         busy_reg <= 8'h00;
      end else begin
         enable_reg <= enable_next;
         status_reg <= status_next;
         busy_reg <= busy_next;
      end
   end

   // ***************************************************
   // read data
   // ***************************************************
   function automatic ais_byte_t read_mux(input logic [15:0] addr,
                                          input ais_byte_t en,
                                          input ais_byte_t st,
                                          input ais_byte_t busy);
      case (addr)
         `AIS_ADDR_ENABLE: read_mux = en;
         `AIS_ADDR_STATUS: read_mux = st;
         `AIS_ADDR_BUSY: read_mux = busy;
         default: read_mux = `AIS_RSVD_READ;
      endcase
   endfunction

   always_comb begin
      rvalid_next = reg_rd_i;
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         rdata_next = read_mux(reg_addr_i, enable_reg, status_reg, busy_reg);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // ***************************************************
   // interrupt pin
   // ***************************************************
   // one cycle behind the flags, in exchange for a glitch-free pin
   always_comb begin
      irq_n_next = ~|(status_reg & enable_reg);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= irq_n_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign reg_rvalid_o = rvalid_reg;
   assign interrupt_out_n_o = irq_n_reg;

   // ***************************************************
   // checks
   // ***************************************************
   chk_lock_loss_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      ((status_reg[7:6] & enable_reg[7:6]) == 2'b00
       && (status_reg[5:0] & enable_reg[5:0]) == 6'h00)
      |=> interrupt_out_n_o)
      else $error("masked lock-loss flag drove the pin");

   chk_holdover_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(status_reg[5:4] & enable_reg[5:4])) |=> !interrupt_out_n_o)
      else $error("enabled holdover flag did not drive the pin");

   chk_sigloss_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(status_reg[3:0] & enable_reg[3:0])) |=> !interrupt_out_n_o)
      else $error("enabled signal-loss flag did not drive the pin");

   chk_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_enable |=> enable_reg == $past(reg_wdata_i))
      else $error("enable register did not take the write");

   chk_event_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      (|events) |=> ((status_reg & $past(events)) == $past(events)))
      else $error("alarm event did not set its flag");

   chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      (|($past(status_reg) & ~status_reg))
      |-> $past(wr_status))
      else $error("flag fell without a clearing write");

   chk_w1c_exact: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_status && events == 8'h00)
      |=> status_reg == ($past(status_reg) & ~$past(reg_wdata_i)))
      else $error("write-one-to-clear gave the wrong flags");

   chk_status_reset: assert property (@(posedge clk_i)
      $past(rst_i) |-> (status_reg == 8'h00 && enable_reg == 8'h00))
      else $error("flags or enables not cleared by reset");

   chk_busy_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && reg_addr_i == `AIS_ADDR_BUSY)
      ##1 reg_rvalid_o |-> reg_rdata_o == $past(busy_reg))
      else $error("busy register read wrong data");

   chk_busy_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 busy_reg == $past(phase_adjust_in_progress_i[7:0]))
      else $error("busy flags do not follow the engine");

   chk_pin_release: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_reg & enable_reg) != 8'h00 ##1 (status_reg & enable_reg) == 8'h00
      |=> interrupt_out_n_o)
      else $error("pin not released when enabled flags cleared");
endmodule

// file: tb/ais_host_model.sv
// host model that drives the register port of the alarm block
`timescale 1ns/1ps
module ais_host_model (
   // clock
   input wire logic clk_i,
   // register port
   output logic [15:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   // ***************************************************
   // bus cycles
   // ***************************************************
   initial begin
      reg_addr_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
   end

   // clears only by writing ones, never by a read
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      // released data shows its inverse, not a stale copy
      reg_wdata_o <= ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      d = 8'hXX;
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         @(posedge clk_i);
         if (reg_rvalid_i === 1'b1) begin
            d = reg_rdata_i;
            break;
         end
      end
   endtask
endmodule

// file: tb/alarm_interrupt_status_tb_top.sv
// self-checking bench for the alarm interrupt status block
`timescale 1ns/1ps
`include "ais_map.svh"
module alarm_interrupt_status_tb_top;
   import ais_pkg::*;
   // ***************************************************
   // stimulus and wiring
   // ***************************************************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] lol = 2'b00;
   logic [1:0] hold = 2'b00;
   logic [3:0] refc = 4'h0;
   logic tick = 1'b0;
   logic [67:0] cnt = {4{17'h1FFFF}};
   logic [7:0] busy = 8'h00;
   logic [15:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   logic irq_n;
   ais_byte_t got;
   int failures = 0;
   int n_checks = 0;

   always #5 clk_i = ~clk_i;

   ais_host_model i_ais_host_model (.clk_i(clk_i), .reg_addr_o(addr),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata),
      .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

   ais_top i_ais_top (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .lock_loss_alarm_i(lol), .holdover_alarm_i(hold),
      .ref_clk_i(refc), .monitor_tick_i(tick),
      .signal_loss_period_count_i(cnt),
      .phase_adjust_in_progress_i(busy), .interrupt_out_n_o(irq_n));

   // ***************************************************
   // compares and helpers
   // ***************************************************
   task automatic chk8(input ais_byte_t g, input ais_byte_t e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic rdchk(input logic [15:0] a, input ais_byte_t e);
      i_ais_host_model.rd(a, got);
      chk8(got, e);
   endtask

   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge clk_i);
         tick <= 1'b1;
         @(posedge clk_i);
         tick <= 1'b0;
      end
   endtask

   task automatic summarize();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one reference edge; restarts that reference's watchdog count
   task automatic ref_pulse(input int b);
      refc[b] <= 1'b1;
      repeat (4) @(posedge clk_i);
      refc[b] <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask

   // pulses one alarm; signal loss goes through its watchdog
   task automatic raise(input int b);
      if (b >= 6) begin
         lol[b-6] <= 1'b1;
         repeat (2) @(posedge clk_i);
         lol[b-6] <= 1'b0;
      end else if (b >= 4) begin
         hold[b-4] <= 1'b1;
         repeat (2) @(posedge clk_i);
         hold[b-4] <= 1'b0;
      end else begin
         // shared ticks ran up this count earlier; zero it first
         ref_pulse(b);
         // a count below the minimum acts as the minimum
         cnt[b*17 +: 17] <= (b == 0) ? 17'h00002 : 17'h00003;
         ticks(2);
         repeat (5) @(posedge clk_i);
         rdchk(`AIS_ADDR_STATUS, 8'h00);
         ticks(1);
         repeat (3) @(posedge clk_i);
         ref_pulse(b);
         cnt[b*17 +: 17] <= 17'h1FFFF;
      end
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      logic [15:0] rsv [4] = '{`AIS_ADDR_EN_RSVD, `AIS_ADDR_ST_RSVD_A,
         `AIS_ADDR_ST_RSVD_B, `AIS_ADDR_ST_RSVD_C};
      rdchk(`AIS_ADDR_ENABLE, `AIS_ENABLE_RST);
      rdchk(`AIS_ADDR_STATUS, `AIS_STATUS_RST);
      chk1(irq_n, 1'b1);
      foreach (rsv[i]) begin
         i_ais_host_model.wr(rsv[i], 8'h00);
         rdchk(rsv[i], `AIS_RSVD_READ);
      end
   endtask

   task automatic t_bit(input int b);
      ais_byte_t m;
      m = 8'h01 << b;
      i_ais_host_model.wr(`AIS_ADDR_ENABLE, ~m);
      raise(b);
      rdchk(`AIS_ADDR_STATUS, m);
      chk1(irq_n, 1'b1);
      i_ais_host_model.wr(`AIS_ADDR_ENABLE, m);
      rdchk(`AIS_ADDR_ENABLE, m);
      chk1(irq_n, 1'b0);
      i_ais_host_model.wr(`AIS_ADDR_STATUS, ~m);
      rdchk(`AIS_ADDR_STATUS, m);
      i_ais_host_model.wr(`AIS_ADDR_STATUS, m);
      rdchk(`AIS_ADDR_STATUS, 8'h00);
      repeat (2) @(posedge clk_i);
      chk1(irq_n, 1'b1);
   endtask

   // busy stands in for the adjust engine; a write to 0204 leaves the flags as they are
   task automatic t_busy();
      busy <= 8'hA5;
      repeat (2) @(posedge clk_i);
      rdchk(`AIS_ADDR_BUSY, 8'hA5);
      busy <= 8'h5A;
      i_ais_host_model.wr(`AIS_ADDR_BUSY, 8'hFF);
      rdchk(`AIS_ADDR_BUSY, 8'h5A);
      busy <= 8'h00;
      rdchk(`AIS_ADDR_BUSY, 8'h00);
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      for (int b = 0; b < 8; b++) begin
         t_bit(b);
      end
      t_busy();
      summarize();
   end

   // a run of about four hundred cycles; some 25 times that means a hang
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule
